// ==== verilog/chan_cmd_device.sv ====
// device end: command register decoder and its on-chip processor model
// assumes: host writes one register per cycle; rdata follows addr next cycle
//
// What this block does
// - commands act on the selected channel
// - upper nibble type, lower nibble parameters
// - command register zeroed after execution
// - host polls for zero before next command
// - channels 0 and 1 ignore commands
// - host selects channel 2/3 before chip reset
// - reset format: channel, chip, flush, unused
// - channel reset disables rx/tx, empties fifos
// - chip reset acts like hardware reset
// - revision cleared at reset start, reloaded after
// - host waits revision zero then nonzero
// - flush empties transmit fifo pointers
// - option-change format with three flags
// - option change refreshes flagged shadow copies
// - special-send format selecting char one-four
// - special char sent ahead of fifo data
// - bit 4 enables/disables tx and rx
module chan_cmd_device #(
  parameter logic [7:0] fw_revision = 8'h5a // arbitrary nonzero value
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  chan_cmd_if.device port,
  input wire logic [7:0] option_reg_one_in,
  input wire logic [7:0] option_reg_two_in,
  input wire logic [7:0] option_reg_three_in,
  output logic [3:0] rx_enable_out,
  output logic [3:0] tx_enable_out,
  output logic [3:0] tx_fifo_flush_out,
  output logic [3:0] rx_fifo_flush_out,
  output logic [2:0] special_send_out,
  output logic [1:0] special_chan_out,
  output logic [23:0] option_shadow_out
);
  // a zero revision would hide reset completion from the host
  if (fw_revision == 8'h00) begin : g_bad_revision
    $error("fw_revision must be nonzero");
  end

  logic [7:0] channel_command_reg_ff;
  logic [1:0] channel_select_reg_ff;
  logic [7:0] firmware_revision_reg_ff;
  logic [7:0] rdata_ff;
  logic [3:0] busy_cnt_ff;
  logic chip_reset_ff;
  logic [7:0] nxt_cmd;
  logic [3:0] rx_en_ff, tx_en_ff, txf_ff, rxf_ff;
  logic [2:0] sp_ff;
  logic [1:0] sp_ch_ff;
  logic [23:0] shadow_ff;

  ////////////////////////////////////////////////////////////////////////
  // register port strobes
  wire cmd_wr = port.wr && port.addr == chan_cmd_pkg::channel_command_off;
  wire sel_wr = port.wr && port.addr == chan_cmd_pkg::channel_select_off;
  wire rev_wr = port.wr && port.addr == chan_cmd_pkg::firmware_revision_off;

  // command byte split into type and parameter nibbles
  wire serial_sel = channel_select_reg_ff[1];
  wire [3:0] cmd_hi = channel_command_reg_ff[7:4];
  wire [3:0] cmd_lo = channel_command_reg_ff[3:0];
  // a command waits out its delay; a reset in progress holds it back
  wire pending = channel_command_reg_ff != 8'h00 && busy_cnt_ff == 4'h0;

  // one decode per format; malformed bytes match none
  wire is_reset = cmd_hi == 4'h8 && cmd_lo[3:2] == 2'b00;
  wire do_chan_rst = is_reset && cmd_lo[1:0] == 2'b00;
  wire do_chip_rst = is_reset && cmd_lo[1:0] == 2'b01;
  wire do_flush = is_reset && cmd_lo[1:0] == 2'b10;
  wire do_option = cmd_hi == 4'h4 && cmd_lo[0] == 1'b0
    && cmd_lo[3:1] != 3'b000;
  wire do_special = cmd_hi == 4'h2 && cmd_lo[3] == 1'b0
    && cmd_lo[2:0] != 3'b000 && cmd_lo[2:0] <= 3'h4;
  wire do_ctl = cmd_hi == 4'h1;

  // target channel, execution strobe and the full-chip wipe
  wire [3:0] ch_mask = 4'b0001 << channel_select_reg_ff;
  wire exec = pending && serial_sel && !chip_reset_ff;
  wire wipe = !rst_b_in || (exec && do_chip_rst);

  ////////////////////////////////////////////////////////////////////////
  // host register port: select, command, revision
  always_ff @(posedge clock_in) begin
    if (!rst_b_in || (exec && do_chip_rst)) begin
      channel_select_reg_ff <= 2'h0;
    end else if (sel_wr) begin
      channel_select_reg_ff <= port.wdata[1:0];
    end
  end

  // command register: write loads, execution zeroes it
  always_comb begin
    nxt_cmd = channel_command_reg_ff;
    if (cmd_wr) nxt_cmd = port.wdata;
    else if (pending && !chip_reset_ff) nxt_cmd = 8'h00;
  end
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      channel_command_reg_ff <= chan_cmd_pkg::channel_command_rst;
      busy_cnt_ff <= 4'h0;
    end else begin
      channel_command_reg_ff <= nxt_cmd;
      // ignored commands on channels 0/1 still clear after the delay
      if (cmd_wr) busy_cnt_ff <= 4'(chan_cmd_pkg::exec_cycles);
      else if (busy_cnt_ff != 4'h0) busy_cnt_ff <= busy_cnt_ff - 4'h1;
    end
  end

  // revision: cleared at reset start, reloaded at completion
  logic [3:0] rst_cnt_ff;
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      chip_reset_ff <= 1'b1;
      rst_cnt_ff <= 4'(chan_cmd_pkg::reset_cycles);
      firmware_revision_reg_ff <= 8'h00;
    end else if (exec && (do_chip_rst || do_chan_rst)) begin
      chip_reset_ff <= 1'b1;
      rst_cnt_ff <= 4'(chan_cmd_pkg::reset_cycles);
      firmware_revision_reg_ff <= 8'h00;
    end else if (chip_reset_ff) begin
      rst_cnt_ff <= rst_cnt_ff - 4'h1;
      if (rst_cnt_ff == 4'h1) begin
        chip_reset_ff <= 1'b0;
        firmware_revision_reg_ff <= fw_revision;
      end
    end else if (rev_wr) begin
      firmware_revision_reg_ff <= port.wdata;
    end
  end

  // read mux, one cycle latency
  wire [7:0] rd_mux =
    port.addr == chan_cmd_pkg::channel_command_off ? channel_command_reg_ff :
    port.addr == chan_cmd_pkg::channel_select_off ?
      {6'h00, channel_select_reg_ff} :
    port.addr == chan_cmd_pkg::firmware_revision_off ?
      firmware_revision_reg_ff : 8'h00;
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) rdata_ff <= 8'h00;
    else rdata_ff <= rd_mux;
  end
  assign port.rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // channel actions
  // receiver and transmitter enables per channel
  always_ff @(posedge clock_in) begin
    if (wipe) begin
      rx_en_ff <= 4'h0;
      tx_en_ff <= 4'h0;
    end else if (exec && do_chan_rst) begin
      rx_en_ff <= rx_en_ff & ~ch_mask;
      tx_en_ff <= tx_en_ff & ~ch_mask;
    end else if (exec && do_ctl) begin
      // a disable bit beats its enable bit
      if (cmd_lo[chan_cmd_pkg::tx_en_bit]) tx_en_ff <= tx_en_ff | ch_mask;
      if (cmd_lo[chan_cmd_pkg::tx_dis_bit]) tx_en_ff <= tx_en_ff & ~ch_mask;
      if (cmd_lo[chan_cmd_pkg::rx_en_bit]) rx_en_ff <= rx_en_ff | ch_mask;
      if (cmd_lo[chan_cmd_pkg::rx_dis_bit]) rx_en_ff <= rx_en_ff & ~ch_mask;
    end
  end

  // one-cycle flush pulses, every channel during a wipe
  always_ff @(posedge clock_in) begin
    if (wipe) begin
      txf_ff <= 4'hf;
      rxf_ff <= 4'hf;
    end else begin
      txf_ff <= exec && (do_chan_rst || do_flush) ? ch_mask : 4'h0;
      rxf_ff <= exec && do_chan_rst ? ch_mask : 4'h0;
    end
  end

  // special character request, one-cycle pulse
  always_ff @(posedge clock_in) begin
    if (wipe) begin
      sp_ff <= 3'h0;
      sp_ch_ff <= 2'h0;
    end else if (exec && do_special) begin
      sp_ff <= cmd_lo[2:0];
      sp_ch_ff <= channel_select_reg_ff;
    end else begin
      sp_ff <= 3'h0;
    end
  end

  // shadow copies of the option registers
  always_ff @(posedge clock_in) begin
    if (wipe) begin
      shadow_ff <= 24'h000000;
    end else if (exec && do_option) begin
      if (cmd_lo[1]) shadow_ff[7:0] <= option_reg_one_in;
      if (cmd_lo[2]) shadow_ff[15:8] <= option_reg_two_in;
      if (cmd_lo[3]) shadow_ff[23:16] <= option_reg_three_in;
    end
  end

  assign rx_enable_out = rx_en_ff;
  assign tx_enable_out = tx_en_ff;
  assign tx_fifo_flush_out = txf_ff;
  assign rx_fifo_flush_out = rxf_ff;
  assign special_send_out = sp_ff;
  assign special_chan_out = sp_ch_ff;
  assign option_shadow_out = shadow_ff;
endmodule

// ==== verilog/chan_cmd_pkg.sv ====
// package: channel command decoder constants and types
// assumes: used by both ends and the monitor, referenced as pkg::name
package chan_cmd_pkg;
  // register offsets on the device's own register port
  localparam logic [7:0] channel_command_off = 8'h05;
  localparam logic [7:0] channel_select_off = 8'h0c;
  localparam logic [7:0] firmware_revision_off = 8'h7f;
  localparam logic [7:0] channel_command_rst = 8'h00;
  // command type bits, then reset parameter bits
  localparam int reset_bit = 7;
  localparam int option_change_bit = 6;
  localparam int special_send_bit = 5;
  localparam int chan_ctl_bit = 4;
  localparam int flush_tx_fifo_bit = 1;
  localparam int reset_type_bit = 0;
  // enable/disable parameter bits
  localparam int tx_en_bit = 3;
  localparam int tx_dis_bit = 2;
  localparam int rx_en_bit = 1;
  localparam int rx_dis_bit = 0;
  // cycles the on-chip processor takes to execute a command
  localparam int exec_cycles = 4;
  localparam int reset_cycles = 8;
  // controller's own AHB registers (byte addresses)
  localparam logic [3:0] host_cmd_addr = 4'h0;
  localparam logic [3:0] host_sel_addr = 4'h4;
  localparam logic [3:0] host_stat_addr = 4'h8;
  localparam logic [3:0] host_rev_addr = 4'hc;
  // host controller states
  typedef enum logic [2:0] {
    h_idle, h_sel, h_cmd, h_poll, h_poll_wait
  } host_state_t;
endpackage

// ==== verilog/chan_cmd_if.sv ====
// interface: device register port between host controller and device
// assumes: one clock, single-cycle write strobe and combinational-free read
interface chan_cmd_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport host (output addr, output wdata, output wr, input rdata);
  modport device (input addr, input wdata, input wr, output rdata);
endinterface

// ==== verilog/chan_cmd_host.sv ====
// host end: AHB-Lite slave that issues commands to the device
// assumes: single-word AHB-Lite transfers, device port answers next cycle
module chan_cmd_host (
  input wire logic clock_in,
  input wire logic rst_b_in,
  chan_cmd_if.host port,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  chan_cmd_pkg::host_state_t state_ff;
  logic [7:0] addr_ff, wdata_ff, cmd_ff, rev_ff;
  logic wr_ff, busy_ff, dph_wr_ff, go_ff, rev_ok_ff;
  logic [1:0] sel_ff;
  logic [3:0] dph_addr_ff;
  logic [31:0] hrdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // ahb address phase capture
  wire take = hsel_in && htrans_in[1] && hready_in;
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      dph_wr_ff <= 1'b0;
      dph_addr_ff <= 4'h0;
    end else begin
      dph_wr_ff <= take && hwrite_in;
      if (take) dph_addr_ff <= haddr_in[3:0];
    end
  end

  // register writes, command accepted only while idle
  wire wr_cmd = dph_wr_ff && dph_addr_ff == chan_cmd_pkg::host_cmd_addr;
  wire wr_sel = dph_wr_ff && dph_addr_ff == chan_cmd_pkg::host_sel_addr;
  // read data is chosen in the address phase so it stands in the data phase
  wire [3:0] rd_addr = haddr_in[3:0];
  wire [31:0] rd_mux =
    rd_addr == chan_cmd_pkg::host_cmd_addr ? {24'h0, cmd_ff} :
    rd_addr == chan_cmd_pkg::host_sel_addr ? {30'h0, sel_ff} :
    rd_addr == chan_cmd_pkg::host_stat_addr ? {31'h0, busy_ff} :
    rd_addr == chan_cmd_pkg::host_rev_addr ? {24'h0, rev_ff} : 32'h0;
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cmd_ff <= 8'h00;
      sel_ff <= 2'h2;
      go_ff <= 1'b0;
      hrdata_ff <= 32'h0;
    end else begin
      go_ff <= wr_cmd && !busy_ff;
      if (wr_cmd && !busy_ff) cmd_ff <= hwdata_in[7:0];
      if (wr_sel && !busy_ff) sel_ff <= hwdata_in[1:0];
      if (take && !hwrite_in) hrdata_ff <= rd_mux;
    end
  end
  assign hrdata_out = hrdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // device sequencer: select, command, poll until zero
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_ff <= chan_cmd_pkg::h_idle;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wr_ff <= 1'b0;
      busy_ff <= 1'b0;
      rev_ff <= 8'h00;
      rev_ok_ff <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      // port read data lags the address by a cycle
      rev_ok_ff <= addr_ff == chan_cmd_pkg::firmware_revision_off;
      case (state_ff)
        chan_cmd_pkg::h_idle: begin
          addr_ff <= chan_cmd_pkg::firmware_revision_off;
          if (rev_ok_ff) rev_ff <= port.rdata;
          if (go_ff) begin
            busy_ff <= 1'b1;
            addr_ff <= chan_cmd_pkg::channel_select_off;
            wdata_ff <= {6'h00, sel_ff};
            wr_ff <= 1'b1;
            state_ff <= chan_cmd_pkg::h_sel;
          end
        end
        chan_cmd_pkg::h_sel: begin
          addr_ff <= chan_cmd_pkg::channel_command_off;
          wdata_ff <= cmd_ff;
          wr_ff <= 1'b1;
          state_ff <= chan_cmd_pkg::h_cmd;
        end
        chan_cmd_pkg::h_cmd: state_ff <= chan_cmd_pkg::h_poll_wait;
        chan_cmd_pkg::h_poll_wait: state_ff <= chan_cmd_pkg::h_poll;
        chan_cmd_pkg::h_poll: begin
          if (port.rdata == 8'h00) begin
            busy_ff <= 1'b0;
            state_ff <= chan_cmd_pkg::h_idle;
          end
        end
        default: state_ff <= chan_cmd_pkg::h_idle;
      endcase
    end
  end
  assign port.addr = addr_ff;
  assign port.wdata = wdata_ff;
  assign port.wr = wr_ff;
endmodule

// ==== tb/chan_cmd_monitor.sv ====
// checker: device register port and decoder outputs
// assumes: instantiated beside the interface, one clock
module chan_cmd_monitor (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic [3:0] rx_enable_out,
  input wire logic [3:0] tx_enable_out,
  input wire logic [3:0] tx_fifo_flush_out,
  input wire logic [3:0] rx_fifo_flush_out,
  input wire logic [2:0] special_send_out,
  input wire logic [1:0] special_chan_out,
  input wire logic [23:0] option_shadow_out,
  input wire logic [7:0] option_reg_one_in
);
  localparam int lat = 12;
  logic [1:0] sel_ff;
  logic [7:0] cmd_ff;
  wire cmd_wr = wr && addr == chan_cmd_pkg::channel_command_off;
  wire sel_wr = wr && addr == chan_cmd_pkg::channel_select_off;
  wire hi = sel_ff[1];
  // last channel select and last command seen on the port
  always_ff @(posedge clock_in) begin
    sel_ff <= !rst_b_in ? 2'h0 : sel_wr ? wdata[1:0] : sel_ff;
    cmd_ff <= !rst_b_in ? 8'h00 : cmd_wr ? wdata : cmd_ff;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  a_flush_tx: assert property (
    cmd_wr && hi && wdata == 8'h82 |-> ##[1:lat] tx_fifo_flush_out[sel_ff])
    else $error("transmit flush missing");
  a_chan_reset: assert property (
    cmd_wr && hi && wdata == 8'h80 |-> ##[1:lat]
    (rx_fifo_flush_out[sel_ff] && tx_fifo_flush_out[sel_ff]))
    else $error("channel reset flush missing");
  a_low_enables: assert property (
    rx_enable_out[1:0] == 2'h0 && tx_enable_out[1:0] == 2'h0)
    else $error("low channel enabled");
  a_special_chan: assert property (
    special_send_out != 3'h0 |-> special_chan_out[1]
    && special_send_out <= 3'h4)
    else $error("bad special send");
  a_special_sel: assert property (
    cmd_wr && hi && wdata[7:3] == 5'h04 && wdata[2:0] != 3'h0
    && wdata[2:0] <= 3'h4 |-> ##[1:lat] special_send_out == cmd_ff[2:0])
    else $error("special char not sent");
  a_special_unused: assert property (
    cmd_wr && wdata == 8'h25 |-> ##1 (special_send_out == 3'h0) [*8])
    else $error("unused special code acted");
  a_option_copy: assert property (
    cmd_wr && hi && wdata == 8'h42 |-> ##[1:lat]
    option_shadow_out[7:0] == option_reg_one_in)
    else $error("option shadow not refreshed");
  a_ctl_enable: assert property (
    cmd_wr && hi && wdata == 8'h1a |-> ##[1:lat]
    (tx_enable_out[sel_ff] && rx_enable_out[sel_ff]))
    else $error("channel not enabled");
endmodule

// ==== tb/serial_channel_command_decoder_bench.sv ====
// testbench: host over AHB-Lite drives the device through the interface
// assumes: hreadyout is the bus hready, one slave
module serial_channel_command_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, rst_b_in, hwrite, hready, hresp, clr;
  logic [1:0] htrans, sp_ch;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] o1, o2, o3;
  logic [3:0] rx_en, tx_en, tx_fl, rx_fl, seen_tx_ff, seen_rx_ff;
  logic [2:0] sp, seen_sp_ff;
  logic [23:0] shadow;
  int fails, n_tests;
  chan_cmd_if bus ();
  chan_cmd_host u_chan_cmd_host (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .port(bus), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp));
  chan_cmd_device u_chan_cmd_device (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .port(bus), .option_reg_one_in(o1),
    .option_reg_two_in(o2), .option_reg_three_in(o3),
    .rx_enable_out(rx_en), .tx_enable_out(tx_en),
    .tx_fifo_flush_out(tx_fl), .rx_fifo_flush_out(rx_fl),
    .special_send_out(sp), .special_chan_out(sp_ch),
    .option_shadow_out(shadow));
  chan_cmd_monitor u_chan_cmd_monitor (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
    .rx_enable_out(rx_en), .tx_enable_out(tx_en),
    .tx_fifo_flush_out(tx_fl), .rx_fifo_flush_out(rx_fl),
    .special_send_out(sp), .special_chan_out(sp_ch),
    .option_shadow_out(shadow), .option_reg_one_in(o1));
  ////////////////////////////////////////////////////////////
  // sticky record of pulses since the last clear
  always @(posedge clock_in) begin
    seen_tx_ff <= clr ? 4'h0 : seen_tx_ff | tx_fl;
    seen_rx_ff <= clr ? 4'h0 : seen_rx_ff | rx_fl;
    if (clr || sp != 3'h0)
      seen_sp_ff <= clr ? 3'h0 : sp;
  end
  task check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single AHB transfer, address then data phase
  task xfer(input logic w, input logic [31:0] a, d);
    @(posedge clock_in);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock_in);
    while (hready !== 1'b1) @(posedge clock_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock_in);
    while (hready !== 1'b1) @(posedge clock_in);
    rd = hrdata;
  endtask
  // select, command, then poll busy until clear
  task issue(input logic [1:0] ch, input logic [7:0] cmd);
    int i;
    clr <= 1'b1;
    xfer(1'b1, 32'h4, {30'h0, ch});
    clr <= 1'b0;
    xfer(1'b1, 32'h0, {24'h0, cmd});
    i = 0;
    do begin
      xfer(1'b0, 32'h8, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 60);
    check("busy", rd[0], 1'b0);
    check("hresp", hresp, 1'b0);
  endtask
  task t_ctl(input logic [1:0] ch);
    logic [7:0] c [4] = '{8'h1a, 8'h19, 8'h16, 8'h15};
    foreach (c[k]) begin
      issue(ch, c[k]);
      check("tx enable", tx_en[ch], c[k][3]);
      check("rx enable", rx_en[ch], c[k][1]);
    end
  endtask
  task t_low();
    issue(2'h0, 8'h1a);
    issue(2'h1, 8'h82);
    check("low chans", {seen_tx_ff[1:0], tx_en[1:0], rx_en[1:0]}, 0);
    xfer(1'b0, 32'h4, 32'h0);
    check("sel read", rd, 32'h1);
    xfer(1'b0, 32'h0, 32'h0);
    check("cmd read", rd, 32'h82);
  endtask
  task t_resets();
    issue(2'h3, 8'h1a);
    issue(2'h2, 8'h1a);
    issue(2'h2, 8'h80);
    check("chan rst en", {tx_en[3:2], rx_en[3:2]}, 4'ha);
    check("chan rst fl", {seen_tx_ff, seen_rx_ff}, 8'h44);
    issue(2'h3, 8'h82);
    check("flush", {seen_tx_ff, seen_rx_ff, tx_en[3]}, 9'h101);
    issue(2'h3, 8'h83);
    check("unused rst", {seen_tx_ff, tx_en[3]}, 5'h01);
  endtask
  task t_special();
    for (int n = 0; n < 8; n++) begin
      issue(2'h3, 8'h20 | n[7:0]);
      check("special", seen_sp_ff, (n >= 1 && n <= 4) ? n[2:0] : 3'h0);
    end
    check("special chan", sp_ch, 2'h3);
  endtask
  task t_option();
    issue(2'h2, 8'h4e);
    check("shadow all", shadow, {o3, o2, o1});
    o1 <= 8'h3c;
    o2 <= 8'hc3;
    o3 <= 8'h99;
    issue(2'h2, 8'h42);
    check("shadow one", shadow, {8'h81, 8'h7e, 8'h3c});
    issue(2'h2, 8'h40);
    check("shadow none", shadow, {8'h81, 8'h7e, 8'h3c});
  endtask
  task t_chip();
    int i;
    issue(2'h3, 8'h1a);
    issue(2'h3, 8'h81);
    check("chip rst", {tx_en, rx_en}, 8'h00);
    i = 0;
    do begin
      xfer(1'b0, 32'hc, 32'h0);
      i++;
    end while (rd[7:0] != 8'h00 && i < 40);
    check("revision clear", rd[7:0], 8'h00);
    do begin
      xfer(1'b0, 32'hc, 32'h0);
      i++;
    end while (rd[7:0] == 8'h00 && i < 80);
    check("revision", |rd[7:0], 1'b1);
  endtask
  task complete_run();
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge clock_in);
    fails++;
    complete_run();
  end
  initial begin
    {rst_b_in, hwrite, clr, htrans, haddr, hwdata} = '0;
    {o1, o2, o3} = {8'h11, 8'h7e, 8'h81};
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (12) @(posedge clock_in);
    check("reset en", {tx_en, rx_en}, 8'h00);
    t_ctl(2'h2);
    t_ctl(2'h3);
    t_low();
    t_resets();
    t_special();
    t_option();
    t_chip();
    complete_run();
  end
endmodule
